// File: verilog/ics_timer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Codes e3 and 97 both start the same idle command.
// R2 - Accepting it loads countdown from timeout count; it enters Idle at once only if the spindle is at speed, else via spin-up.
// R3 - The countdown starts decrementing right after loading, no further host action.
// R4 - Entering Idle spins the spindle up unless it is already at speed.
// R5 - In Idle the spindle keeps turning and commands are taken without delay.
// R6 - Count zero disables power-down; other non-abort values enable it.
// R7 - 1..240 give value times five units; 241..251 give (value-240) half hours.
// R8 - 252 is 21 min, 253 is 8 h, 255 is 21 min 15 s, 254 aborts.
// R9 - When enabled and the countdown expires without access, enter Standby.
// R10 - Any host access before expiry reloads the full interval.
// R11 - Abort ends with busy clear, error set, only abort bit; else error cleared.
// R12 - The five-unit range counts in seconds.
module ics_timer
	import ics_pkg::*;
#(
	parameter int CYC_PER_SEC = ICS_CYC_PER_SEC
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [ICS_AW-1:0] reg_addr,
	input  wire logic [ICS_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [ICS_DW-1:0] reg_rdata,
	input  wire logic              spindle_at_speed,
	output logic                   motor_on,
	output logic      [1:0]        power_state,
	output logic                   irq
);
	localparam int DIVW = $clog2(CYC_PER_SEC + 1);

	logic [ICS_DW-1:0]    count_q;
	logic [ICS_DW-1:0]    head_q;
	logic [ICS_DW-1:0]    rdata_q;
	logic [ICS_DW-1:0]    err_q;
	logic                 errf_q;
	logic                 motor_q;
	logic                 sp_meta_q;
	logic                 sp_sync_q;
	ics_pwr_e             state_q;
	logic                 armed_q;
	logic [ICS_TW-1:0]    interval_q;
	logic [ICS_TW-1:0]    remain_q;
	logic [DIVW-1:0]      div_q;
	logic                 tick;
	logic [ICS_IRQ_W-1:0] istat_q;
	logic [ICS_IRQ_W-1:0] imask_q;
	logic                 irq_q;
	logic                 host_acc;
	logic                 busy;
	logic                 cmd_go;
	logic                 cmd_abort;
	logic                 cmd_run;
	logic                 expire;
	logic                 spin_done;
	logic [ICS_DW-1:0]    stat;

	assign busy      = (state_q == ICS_PW_SPINUP);
	assign host_acc  = reg_wr | reg_rd;
	assign cmd_go    = reg_wr && reg_addr == ICS_REG_CMD && !busy &&
		(reg_wdata == ICS_CMD_IDLE_A || reg_wdata == ICS_CMD_IDLE_B); // R1
	assign cmd_abort = cmd_go && count_q == ICS_SC_ABORT; // R8
	assign cmd_run   = cmd_go && count_q != ICS_SC_ABORT;
	assign tick      = (div_q == DIVW'(CYC_PER_SEC - 1));
	assign expire    = armed_q && tick && remain_q == ICS_TW'(1) &&
		state_q == ICS_PW_IDLE && !host_acc; // R9
	assign spin_done = busy && sp_sync_q;

	always_comb begin
		stat               = '0;
		stat[ICS_ST_BUSY]  = busy; // R11
		stat[ICS_ST_READY] = !busy;
		stat[ICS_ST_FAULT] = 1'b0;
		stat[ICS_ST_SEEK]  = (state_q == ICS_PW_IDLE);
		stat[ICS_ST_ERR]   = errf_q;
	end

	// Spindle speed comes from the motor driver, off this clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sp_meta_q <= 1'b0;
			sp_sync_q <= 1'b0;
		end else begin
			sp_meta_q <= spindle_at_speed;
			sp_sync_q <= sp_meta_q;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
			head_q  <= '0;
			imask_q <= '0;
		end else if (reg_wr) begin
			if (reg_addr == ICS_REG_COUNT) begin
				count_q <= reg_wdata;
			end
			if (reg_addr == ICS_REG_HEAD) begin
				head_q <= reg_wdata;
			end
			if (reg_addr == ICS_REG_IMASK) begin
				imask_q <= reg_wdata[ICS_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err_q  <= '0;
			errf_q <= 1'b0;
		end else if (cmd_abort) begin
			err_q               <= '0; // R11
			err_q[ICS_ER_ABORT] <= 1'b1; // R11
			errf_q              <= 1'b1;
		end else if (cmd_run) begin
			err_q  <= '0; // R11
			errf_q <= 1'b0;
		end
	end

	// Power state; commands during spin-up are ignored since the host sees busy
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ICS_PW_STANDBY;
			motor_q <= 1'b0;
		end else begin
			unique case (state_q)
				ICS_PW_STANDBY: begin
					if (cmd_run) begin
						motor_q <= 1'b1; // R4
						state_q <= sp_sync_q ? ICS_PW_IDLE : ICS_PW_SPINUP; // R2 R4
					end
				end
				ICS_PW_SPINUP: begin
					if (sp_sync_q) begin
						state_q <= ICS_PW_IDLE;
					end
				end
				ICS_PW_IDLE: begin
					if (expire) begin
						state_q <= ICS_PW_STANDBY; // R9
						motor_q <= 1'b0;
					end else begin
						motor_q <= 1'b1; // R5
					end
				end
				default: begin
					state_q <= ICS_PW_STANDBY;
					motor_q <= 1'b0;
				end
			endcase
		end
	end

	// Divider restarts on every load so the interval is whole seconds, not up to one short
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
		end else if (cmd_run || host_acc || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIVW'(1); // R12
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			armed_q    <= 1'b0;
			interval_q <= '0;
			remain_q   <= '0;
		end else if (cmd_run) begin
			armed_q    <= (count_q != ICS_SC_OFF); // R6
			interval_q <= ics_interval(count_q); // R7 R8 R12
			remain_q   <= ics_interval(count_q); // R2
		end else if (expire) begin
			armed_q <= 1'b0;
		end else if (armed_q && host_acc) begin
			remain_q <= interval_q; // R10
		end else if (armed_q && tick && remain_q > ICS_TW'(1)) begin
			remain_q <= remain_q - ICS_TW'(1); // R3
		end
	end

	// Set beats a same-cycle write-one-to-clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istat_q & ~((reg_wr && reg_addr == ICS_REG_ISTAT) ?
				reg_wdata[ICS_IRQ_W-1:0] : '0))
				| ({{(ICS_IRQ_W-1){1'b0}}, (cmd_run && sp_sync_q) || spin_done} // R11
					<< ICS_IRQ_DONE)
				| ({{(ICS_IRQ_W-1){1'b0}}, expire} << ICS_IRQ_STBY);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(istat_q & imask_q);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ICS_REG_COUNT: rdata_q <= count_q;
				ICS_REG_HEAD:  rdata_q <= head_q;
				ICS_REG_ERR:   rdata_q <= err_q;
				ICS_REG_STAT:  rdata_q <= stat;
				ICS_REG_ISTAT: rdata_q <= ICS_DW'(istat_q);
				ICS_REG_IMASK: rdata_q <= ICS_DW'(imask_q);
				ICS_REG_POWER: rdata_q <= ICS_DW'(state_q);
				default:       rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata   = rdata_q;
	assign motor_on    = motor_q;
	assign power_state = state_q;
	assign irq         = irq_q;

	property p_code_b;
		@(posedge clk) disable iff (reset)
		(reg_wr && reg_addr == ICS_REG_CMD && reg_wdata == ICS_CMD_IDLE_B && !busy &&
			count_q != ICS_SC_ABORT) |=> state_q != ICS_PW_STANDBY;
	endproperty
	a_code_b: assert property (p_code_b) else $error("second idle code ignored"); // R1

	property p_load;
		@(posedge clk) disable iff (reset)
		cmd_run |=> remain_q == ics_interval($past(count_q)) && armed_q == ($past(count_q) != 0);
	endproperty
	a_load: assert property (p_load) else $error("countdown not loaded"); // R2

	property p_dec;
		@(posedge clk) disable iff (reset)
		(armed_q && tick && remain_q > 1 && !host_acc && !cmd_run)
			|=> remain_q == $past(remain_q) - 1;
	endproperty
	a_dec: assert property (p_dec) else $error("countdown did not step"); // R3

	property p_skip_spin;
		@(posedge clk) disable iff (reset)
		(cmd_run && state_q == ICS_PW_STANDBY && sp_sync_q) |=> state_q == ICS_PW_IDLE && motor_q;
	endproperty
	a_skip_spin: assert property (p_skip_spin) else $error("spin-up not skipped"); // R4

	property p_idle_spin;
		@(posedge clk) disable iff (reset)
		(state_q == ICS_PW_IDLE && !expire) |=> motor_q && !busy;
	endproperty
	a_idle_spin: assert property (p_idle_spin) else $error("idle lost spindle"); // R5

	property p_8h;
		@(posedge clk) disable iff (reset)
		(cmd_run && count_q == ICS_SC_8H) |=> interval_q == 15'h7080;
	endproperty
	a_8h: assert property (p_8h) else $error("eight hour code wrong"); // R8

	property p_expire;
		@(posedge clk) disable iff (reset)
		// A host may restart the drive one cycle after expiry
		expire |=> state_q == ICS_PW_STANDBY && !motor_q ##1 (!motor_q || $past(cmd_run));
	endproperty
	a_expire: assert property (p_expire) else $error("no standby on expiry"); // R9

	property p_reload;
		@(posedge clk) disable iff (reset)
		(armed_q && host_acc && !cmd_run && !expire) |=> remain_q == interval_q;
	endproperty
	a_reload: assert property (p_reload) else $error("access did not reload"); // R10

	property p_abort;
		@(posedge clk) disable iff (reset)
		cmd_abort |=> err_q == 8'h04 && errf_q && !busy && state_q == $past(state_q);
	endproperty
	a_abort: assert property (p_abort) else $error("abort completion wrong"); // R11

	property p_abort_quiet;
		@(posedge clk) disable iff (reset)
		cmd_abort |=> !istat_q[ICS_IRQ_DONE] || $past(istat_q[ICS_IRQ_DONE]);
	endproperty
	a_abort_quiet: assert property (p_abort_quiet) else $error("abort raised done"); // R11

	property p_zero_off;
		@(posedge clk) disable iff (reset)
		(cmd_run && count_q == ICS_SC_OFF) |=> !armed_q;
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("zero count left timer armed"); // R6

	property p_lin;
		@(posedge clk) disable iff (reset)
		(cmd_run && count_q != ICS_SC_OFF && count_q <= ICS_SC_LIN_MAX)
			|=> interval_q == ICS_TW'($past(count_q)) * ICS_TW'(ICS_LIN_UNIT_S);
	endproperty
	a_lin: assert property (p_lin) else $error("linear interval wrong"); // R7 R12

	property p_half;
		@(posedge clk) disable iff (reset)
		(cmd_run && count_q > ICS_SC_LIN_MAX && count_q <= ICS_SC_HALF_MAX)
			|=> interval_q == ICS_TW'($past(count_q) - ICS_SC_LIN_MAX) * ICS_TW'(ICS_HALF_UNIT_S);
	endproperty
	a_half: assert property (p_half) else $error("half hour interval wrong"); // R7
endmodule
`default_nettype wire

// File: verilog/ics_pkg.sv
package ics_pkg;
	localparam int ICS_AW = 3;
	localparam int ICS_DW = 8;
	localparam int ICS_TW = 15;

	localparam logic [ICS_AW-1:0] ICS_REG_COUNT = 3'h0;
	localparam logic [ICS_AW-1:0] ICS_REG_HEAD  = 3'h1;
	localparam logic [ICS_AW-1:0] ICS_REG_CMD   = 3'h2;
	localparam logic [ICS_AW-1:0] ICS_REG_ERR   = 3'h3;
	localparam logic [ICS_AW-1:0] ICS_REG_STAT  = 3'h4;
	localparam logic [ICS_AW-1:0] ICS_REG_ISTAT = 3'h5;
	localparam logic [ICS_AW-1:0] ICS_REG_IMASK = 3'h6;
	localparam logic [ICS_AW-1:0] ICS_REG_POWER = 3'h7;

	localparam logic [ICS_DW-1:0] ICS_CMD_IDLE_A = 8'he3;
	localparam logic [ICS_DW-1:0] ICS_CMD_IDLE_B = 8'h97;

	localparam logic [ICS_DW-1:0] ICS_SC_OFF      = 8'h00;
	localparam logic [ICS_DW-1:0] ICS_SC_LIN_MAX  = 8'hf0;
	localparam logic [ICS_DW-1:0] ICS_SC_HALF_MAX = 8'hfb;
	localparam logic [ICS_DW-1:0] ICS_SC_21M      = 8'hfc;
	localparam logic [ICS_DW-1:0] ICS_SC_8H       = 8'hfd;
	localparam logic [ICS_DW-1:0] ICS_SC_ABORT    = 8'hfe;

	localparam int ICS_LIN_UNIT_S  = 5;
	localparam int ICS_HALF_UNIT_S = 30 * 60;
	localparam int ICS_T21M_S      = 21 * 60;
	localparam int ICS_T8H_S       = 8 * 3600;
	localparam int ICS_T21M15_S    = 21 * 60 + 15;

	localparam longint ICS_CLK_HZ = 250_000_000;
	localparam int     ICS_TICK_S = 1;
	localparam int     ICS_CYC_PER_SEC = int'(ICS_CLK_HZ * ICS_TICK_S);

	localparam int ICS_ST_BUSY  = 7;
	localparam int ICS_ST_READY = 6;
	localparam int ICS_ST_FAULT = 5;
	localparam int ICS_ST_SEEK  = 4;
	localparam int ICS_ST_ERR   = 0;
	localparam int ICS_ER_ABORT = 2;

	localparam int ICS_IRQ_W    = 2;
	localparam int ICS_IRQ_DONE = 0;
	localparam int ICS_IRQ_STBY = 1;

	typedef enum logic [1:0] {
		ICS_PW_STANDBY = 2'b00,
		ICS_PW_SPINUP  = 2'b01,
		ICS_PW_IDLE    = 2'b10
	} ics_pwr_e;

	function automatic logic [ICS_TW-1:0] ics_interval(input logic [ICS_DW-1:0] v);
		logic [ICS_TW-1:0] r;
		r = '0;
		if (v <= ICS_SC_LIN_MAX) begin
			r = ICS_TW'(ICS_TW'(v) * ICS_TW'(ICS_LIN_UNIT_S));
		end else if (v <= ICS_SC_HALF_MAX) begin
			r = ICS_TW'(ICS_TW'(v - ICS_SC_LIN_MAX) * ICS_TW'(ICS_HALF_UNIT_S));
		end else if (v == ICS_SC_21M) begin
			r = ICS_TW'(ICS_T21M_S);
		end else if (v == ICS_SC_8H) begin
			r = ICS_TW'(ICS_T8H_S);
		end else begin
			r = ICS_TW'(ICS_T21M15_S);
		end
		return r;
	endfunction
endpackage

// File: verification/ics_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ics_motor_model #(
	parameter int SPIN = 12
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic motor_on,
	output logic      at_speed
);
	int cnt_q;
	// Speed drops at once when the drive stops, so no stale at-speed level lingers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q    <= 0;
			at_speed <= 1'b0;
		end else if (!motor_on) begin
			cnt_q    <= 0;
			at_speed <= 1'b0;
		end else if (cnt_q < SPIN) begin
			cnt_q <= cnt_q + 1;
		end else begin
			at_speed <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: verification/ics_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ics_timer_tb;
	import ics_pkg::*;
	localparam int CPS = 4;
	typedef struct {
		logic [7:0] cnt;
		logic [7:0] cmd;
		logic [7:0] err;
		logic [1:0] pw;
	} ics_row_s;
	logic              clk;
	logic              reset;
	logic [ICS_AW-1:0] reg_addr;
	logic [ICS_DW-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [ICS_DW-1:0] reg_rdata;
	logic              at_speed;
	logic              motor_on;
	logic [1:0]        power_state;
	logic              irq;
	int                err_count = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	int                wt = 0;
	logic [7:0]        d;
	ics_row_s          rows [4] = '{'{8'h05, 8'he3, 8'h00, 2'b01}, '{8'h05, 8'h97, 8'h00, 2'b10},
		'{8'hfe, 8'he3, 8'h04, 2'b10}, '{8'h00, 8'h97, 8'h00, 2'b10}};

	ics_timer #(.CYC_PER_SEC(CPS)) u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.spindle_at_speed(at_speed), .motor_on(motor_on), .power_state(power_state), .irq(irq));
	ics_motor_model u_motor (.clk(clk), .reset(reset), .motor_on(motor_on), .at_speed(at_speed));

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (power_state !== 2'b10 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk("reach_idle", 8'h02, {6'h0, power_state});
	endtask

	// Pokes land just short of expiry; each one must restart the full interval
	task automatic expire(input logic [7:0] cnt, input int secs, input int pokes);
		int n;
		int lim;
		lim = secs * CPS;
		wr(ICS_REG_COUNT, cnt);
		wr(ICS_REG_CMD, ICS_CMD_IDLE_A);
		wait_idle();
		rd(ICS_REG_STAT, d);
		for (int i = 0; i < pokes; i++) begin
			repeat (lim - 8) @(posedge clk);
			rd(ICS_REG_STAT, d);
		end
		chk("no_early_stby", 8'h02, {6'h0, power_state});
		n = 0;
		while (power_state !== 2'b00 && n < lim + 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk("expiry_time", 8'h01, {7'h0, (n >= lim - 4 && n <= lim + 4)});
		chk("stby_motor", 8'h00, {7'h0, motor_on});
		// The interrupt line trails the status bit by one cycle
		@(posedge clk);
		#1 chk("stby_irq", 8'h01, {7'h0, irq});
		wr(ICS_REG_ISTAT, 8'h03);
		@(posedge clk);
		#1 chk("irq_clear", 8'h00, {7'h0, irq});
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		reset     = 1'b1;
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(ICS_REG_POWER, d);
		chk("rst_power", 8'h00, d);
		rd(ICS_REG_ERR, d);
		chk("rst_err", 8'h00, d);
		chk("rst_motor", 8'h00, {6'h0, motor_on, irq});
		wr(ICS_REG_IMASK, 8'h02);
		foreach (rows[i]) begin
			wr(ICS_REG_COUNT, rows[i].cnt);
			wr(ICS_REG_CMD, rows[i].cmd);
			#1 chk("pw_now", {6'h0, rows[i].pw}, {6'h0, power_state});
			wait_idle();
			rd(ICS_REG_ERR, d);
			chk("err_reg", rows[i].err, d);
			rd(ICS_REG_STAT, d);
			chk("stat_bsy_err", {7'h0, rows[i].err[ICS_ER_ABORT]},
				{d[ICS_ST_BUSY], 6'h0, d[ICS_ST_ERR]});
			chk("spinning", 8'h01, {7'h0, motor_on});
		end
		repeat (200) @(posedge clk);
		#1 chk("zero_no_stby", 8'h02, {6'h0, power_state});
		rd(ICS_REG_CMD, d);
		chk("cmd_reads_0", 8'h00, d);
		expire(8'h01, 5, 0);
		expire(8'h02, 10, 4);
		expire(8'hf0, 1200, 0);
		expire(8'hf1, 1800, 0);
		expire(8'hfc, 1260, 0);
		expire(8'hff, 1275, 0);
		// Command lands while the synchroniser still holds the at-speed level after expiry: no spin-up
		wr(ICS_REG_COUNT, 8'h01);
		wr(ICS_REG_CMD, ICS_CMD_IDLE_B);
		wait_idle();
		wr(ICS_REG_ISTAT, 8'h03);
		while (power_state !== 2'b00 && wt < 40) begin
			@(posedge clk);
			#1 wt++;
		end
		wr(ICS_REG_CMD, ICS_CMD_IDLE_B);
		#1 chk("coast_idle", 8'h02, {6'h0, power_state});
		rd(ICS_REG_ISTAT, d);
		chk("coast_istat", 8'h03, d);
		// Reset in mid-run must drop the motor and clear every flag
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1 chk("rst2_out", 8'h00, {4'h0, irq, motor_on, power_state});
		rd(ICS_REG_ISTAT, d);
		chk("rst2_istat", 8'h00, d);
		rd(ICS_REG_ERR, d);
		chk("rst2_err", 8'h00, d);
		give_verdict();
	end
endmodule
`default_nettype wire
